// *** inc/aqcd_pkg.sv ***
// Shared constants and types for the analog quad configuration decoder
package aqcd_pkg;

  // Byte index of each pad inside a quad
  localparam logic [1:0] BYTE_VOLTAGE = 2'h0;
  localparam logic [1:0] BYTE_CURRENT = 2'h1;
  localparam logic [1:0] BYTE_GATE = 2'h2;
  localparam logic [1:0] BYTE_THERMAL = 2'h3;
  localparam int BYTE_COUNT = 4;

  // Field positions shared by voltage, current and thermal pad bytes
  localparam int SCALE_LSB = 0;
  localparam int SCALE_MSB = 2;
  localparam int MUX_LSB = 3;
  localparam int MUX_MSB = 4;
  localparam int DIRECT_BIT = 5;
  localparam int POLARITY_BIT = 6;
  localparam int OPAMP_BIT = 7;

  // Field positions only in the voltage pad byte
  localparam int CURMON_BIT = 4;

  // Field positions of the gate pad byte
  localparam int TEMPMON_BIT = 0;
  localparam int DRIVE_LSB = 2;
  localparam int DRIVE_MSB = 3;
  localparam int GATE_POL_BIT = 6;
  localparam int HIGH_DRIVE_BIT = 7;

  // Multiplexer codes
  localparam logic [1:0] MUX_PRESCALER = 2'h0;
  localparam logic [1:0] MUX_DIRECT = 2'h1;
  localparam logic [1:0] MUX_MONITOR = 2'h2;
  localparam logic [1:0] MUX_INVALID = 2'h3;

  // Prescaler codes allowed for the temperature monitor
  localparam logic [2:0] SCALE_16V = 3'h0;
  localparam logic [2:0] SCALE_4V = 3'h2;

  // Low-drive current codes: 1, 3, 10 and 30 microamps
  localparam logic [1:0] DRIVE_1UA = 2'h0;
  localparam logic [1:0] DRIVE_3UA = 2'h1;
  localparam logic [1:0] DRIVE_10UA = 2'h2;
  localparam logic [1:0] DRIVE_30UA = 2'h3;

  // Power-up defaults: highest range, prescaler, switches off, positive, off
  localparam logic [7:0] VOLTAGE_RESET = 8'h00;
  localparam logic [7:0] CURRENT_RESET = 8'h00;
  localparam logic [7:0] GATE_RESET = 8'h00;
  localparam logic [7:0] THERMAL_RESET = 8'h00;

  typedef enum logic [1:0] {
    ROUTE_PRESCALER,
    ROUTE_DIRECT,
    ROUTE_MONITOR,
    ROUTE_NONE
  } aqcd_route_type;

  typedef enum logic [1:0] {
    GATE_OFF,
    GATE_LOW_DRIVE,
    GATE_HIGH_DRIVE
  } aqcd_drive_type;

endpackage : aqcd_pkg

// *** rtl/aqcd_pad_decode.sv ***
// Decoder for one voltage, current or thermal pad configuration byte
`timescale 1ns/1ns
module aqcd_pad_decode (
  input logic [7:0] cfg_byte,
  output logic [2:0] scale_sel,
  output aqcd_pkg::aqcd_route_type route,
  output logic route_invalid,
  output logic direct_switch_on,
  output logic polarity_negative,
  output logic opamp_on
);

  always_comb begin
    case (cfg_byte[aqcd_pkg::MUX_MSB:aqcd_pkg::MUX_LSB]) // [RQ1]
      aqcd_pkg::MUX_PRESCALER: route = aqcd_pkg::ROUTE_PRESCALER;
      aqcd_pkg::MUX_DIRECT: route = aqcd_pkg::ROUTE_DIRECT;
      aqcd_pkg::MUX_MONITOR: route = aqcd_pkg::ROUTE_MONITOR;
      // Forbidden code connects nothing rather than guess
      default: route = aqcd_pkg::ROUTE_NONE;
    endcase
  end

  assign route_invalid = (cfg_byte[aqcd_pkg::MUX_MSB:aqcd_pkg::MUX_LSB]
    == aqcd_pkg::MUX_INVALID); // [RQ1]
  assign scale_sel = cfg_byte[aqcd_pkg::SCALE_MSB:aqcd_pkg::SCALE_LSB]; // [RQ12]
  assign direct_switch_on = cfg_byte[aqcd_pkg::DIRECT_BIT]; // [RQ2]
  assign polarity_negative = cfg_byte[aqcd_pkg::POLARITY_BIT]; // [RQ3]
  assign opamp_on = cfg_byte[aqcd_pkg::OPAMP_BIT]; // [RQ5]

endmodule : aqcd_pad_decode

// *** rtl/aqcd_quad_config.sv ***
// Analog quad configuration byte storage and control line decoding
`timescale 1ns/1ns
// Requirements on this block and on its configuring party
// RQ1: Bits 4:3 route ADC to prescaler, direct input or monitor; 11 is invalid.
// RQ2: Bit 5 opens or closes the pad's direct analog input switch.
// RQ3: Bit 6 selects positive or negative input polarity of the pad.
// RQ4: Configuring party keeps thermal pad bit 6 at zero.
// RQ5: Bit 7 powers the pad prescaler op amp down or up.
// RQ6: Voltage pad bit 4 switches the current monitor input off or on.
// RQ7: Gate bits 3:2 pick low-drive current of 1, 3, 10 or 30 microamps.
// RQ8: Gate bit 6 selects positive or negative gate driver polarity.
// RQ9: Gate drive off without drive-on input; else bit 7 picks low or high.
// RQ10: Temperature monitor enable follows gate pad bit 0.
// RQ11: Configuring party sets gate bit 0 in all ten quads for monitoring.
// RQ12: Bits 2:0 pick prescaler scale; thermal monitor uses only 000 or 010.
// RQ13: Four bytes per quad: voltage, current, gate, thermal pads.
// RQ14: Bytes take defaults at reset and hold until written.
// RQ15: Bytes are stored from the port; control lines decode combinationally.
module aqcd_quad_config (
  input logic clk,
  input logic reset,
  input logic cfg_write,
  input logic cfg_read,
  input logic [1:0] cfg_addr,
  input logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  input logic gate_drive_on_input,
  output logic [2:0] voltage_pad_scale,
  output aqcd_pkg::aqcd_route_type voltage_pad_route,
  output logic voltage_pad_route_invalid,
  output logic voltage_pad_direct_on,
  output logic voltage_pad_negative,
  output logic voltage_pad_opamp_on,
  output logic current_monitor_switch_on,
  output logic [2:0] current_pad_scale,
  output aqcd_pkg::aqcd_route_type current_pad_route,
  output logic current_pad_route_invalid,
  output logic current_pad_direct_on,
  output logic current_pad_negative,
  output logic current_pad_opamp_on,
  output logic [2:0] thermal_pad_scale,
  output aqcd_pkg::aqcd_route_type thermal_pad_route,
  output logic thermal_pad_route_invalid,
  output logic thermal_pad_direct_on,
  output logic thermal_pad_negative,
  output logic thermal_pad_opamp_on,
  output logic [1:0] gate_pad_current,
  output logic gate_pad_negative,
  output aqcd_pkg::aqcd_drive_type gate_pad_drive,
  output logic temp_monitor_enable_control
);

  logic [7:0] voltage_pad_config;
  logic [7:0] current_pad_config;
  logic [7:0] gate_pad_config;
  logic [7:0] thermal_pad_config;
  logic [7:0] next_rdata;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Configuration byte storage, one byte per pad
  always_ff @(posedge clk) begin
    if (reset) begin
      voltage_pad_config <= aqcd_pkg::VOLTAGE_RESET; // [RQ14]
      current_pad_config <= aqcd_pkg::CURRENT_RESET; // [RQ14]
      gate_pad_config <= aqcd_pkg::GATE_RESET; // [RQ14]
      thermal_pad_config <= aqcd_pkg::THERMAL_RESET; // [RQ14]
    end else if (cfg_write) begin
      // Spare bits are kept so software reads back what it wrote
      if (cfg_addr == aqcd_pkg::BYTE_VOLTAGE) begin
        voltage_pad_config <= cfg_wdata; // [RQ13] [RQ15]
      end else if (cfg_addr == aqcd_pkg::BYTE_CURRENT) begin
        current_pad_config <= cfg_wdata; // [RQ13] [RQ15]
      end else if (cfg_addr == aqcd_pkg::BYTE_GATE) begin
        gate_pad_config <= cfg_wdata; // [RQ13] [RQ15]
      end else begin
        thermal_pad_config <= cfg_wdata; // [RQ13] [RQ15]
      end
    end
  end

  // Read path
  always_comb begin
    if (cfg_addr == aqcd_pkg::BYTE_VOLTAGE) begin
      next_rdata = voltage_pad_config;
    end else if (cfg_addr == aqcd_pkg::BYTE_CURRENT) begin
      next_rdata = current_pad_config;
    end else if (cfg_addr == aqcd_pkg::BYTE_GATE) begin
      next_rdata = gate_pad_config;
    end else begin
      next_rdata = thermal_pad_config;
    end
  end

  // Registered read data; a same-cycle write is seen on the next read
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_rdata <= 8'h00;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_read;
      if (cfg_read) begin
        cfg_rdata <= next_rdata;
      end
    end
  end

  aqcd_pad_decode u_voltage (
    .cfg_byte(voltage_pad_config),
    .scale_sel(voltage_pad_scale),
    .route(voltage_pad_route),
    .route_invalid(voltage_pad_route_invalid),
    .direct_switch_on(voltage_pad_direct_on),
    .polarity_negative(voltage_pad_negative),
    .opamp_on(voltage_pad_opamp_on)
  );

  aqcd_pad_decode u_current (
    .cfg_byte(current_pad_config),
    .scale_sel(current_pad_scale),
    .route(current_pad_route),
    .route_invalid(current_pad_route_invalid),
    .direct_switch_on(current_pad_direct_on),
    .polarity_negative(current_pad_negative),
    .opamp_on(current_pad_opamp_on)
  );

  // Thermal polarity is decoded as stored; keeping it positive is software's job
  aqcd_pad_decode u_thermal (
    .cfg_byte(thermal_pad_config),
    .scale_sel(thermal_pad_scale),
    .route(thermal_pad_route),
    .route_invalid(thermal_pad_route_invalid),
    .direct_switch_on(thermal_pad_direct_on),
    .polarity_negative(thermal_pad_negative), // [RQ4]
    .opamp_on(thermal_pad_opamp_on)
  );

  // Shares bit 4 with the voltage pad multiplexer code
  assign current_monitor_switch_on = voltage_pad_config[aqcd_pkg::CURMON_BIT]; // [RQ6]

  // Gate pad decoding
  assign gate_pad_current =
    gate_pad_config[aqcd_pkg::DRIVE_MSB:aqcd_pkg::DRIVE_LSB]; // [RQ7]
  assign gate_pad_negative = gate_pad_config[aqcd_pkg::GATE_POL_BIT]; // [RQ8]
  // Each quad drives only its share; the monitor needs all ten enabled
  assign temp_monitor_enable_control = gate_pad_config[aqcd_pkg::TEMPMON_BIT]; // [RQ10] [RQ11]

  always_comb begin
    if (!gate_drive_on_input) begin
      gate_pad_drive = aqcd_pkg::GATE_OFF; // [RQ9]
    end else if (gate_pad_config[aqcd_pkg::HIGH_DRIVE_BIT]) begin
      gate_pad_drive = aqcd_pkg::GATE_HIGH_DRIVE; // [RQ9]
    end else begin
      gate_pad_drive = aqcd_pkg::GATE_LOW_DRIVE; // [RQ9] [RQ7]
    end
  end

  // Checks
  a_reset_defaults: assert property ( // [RQ14]
    $past(reset) |-> (voltage_pad_route == aqcd_pkg::ROUTE_PRESCALER)
      && !voltage_pad_direct_on && !current_monitor_switch_on
      && !current_pad_opamp_on && !thermal_pad_negative
      && (gate_pad_current == aqcd_pkg::DRIVE_1UA)
      && !temp_monitor_enable_control && (thermal_pad_scale == aqcd_pkg::SCALE_16V))
    else $error("config bytes not at defaults after reset");

  a_bytes_hold: assert property ( // [RQ14]
    !cfg_write |=> $stable(voltage_pad_config) && $stable(current_pad_config)
      && $stable(gate_pad_config) && $stable(thermal_pad_config))
    else $error("config byte changed without a write");

  a_write_readback: assert property ( // [RQ15]
    (cfg_write ##1 (cfg_read && !cfg_write && cfg_addr == $past(cfg_addr)))
      |=> cfg_rvalid && (cfg_rdata == $past(cfg_wdata, 2)))
    else $error("read back differs from written byte");

  a_read_answer: assert property ( // [RQ15]
    cfg_read |=> cfg_rvalid ##1 ($past(cfg_read) == cfg_rvalid))
    else $error("read answer not one cycle after request");

  a_route_select: assert property ( // [RQ1]
    (cfg_write && cfg_addr == aqcd_pkg::BYTE_CURRENT
      && cfg_wdata[aqcd_pkg::MUX_MSB:aqcd_pkg::MUX_LSB] == aqcd_pkg::MUX_DIRECT)
      |=> (current_pad_route == aqcd_pkg::ROUTE_DIRECT) && !current_pad_route_invalid)
    else $error("current pad not routed to direct input");

  a_route_invalid: assert property ( // [RQ1]
    (cfg_write && cfg_addr == aqcd_pkg::BYTE_THERMAL
      && cfg_wdata[aqcd_pkg::MUX_MSB:aqcd_pkg::MUX_LSB] == aqcd_pkg::MUX_INVALID)
      |=> thermal_pad_route_invalid && (thermal_pad_route == aqcd_pkg::ROUTE_NONE))
    else $error("invalid multiplexer code not flagged");

  a_direct_switch: assert property ( // [RQ2]
    (cfg_write && cfg_addr == aqcd_pkg::BYTE_VOLTAGE)
      |=> voltage_pad_direct_on == $past(cfg_wdata[aqcd_pkg::DIRECT_BIT]))
    else $error("direct switch does not follow bit 5");

  a_pad_polarity: assert property ( // [RQ3]
    (cfg_write && cfg_addr == aqcd_pkg::BYTE_CURRENT)
      |=> current_pad_negative == $past(cfg_wdata[aqcd_pkg::POLARITY_BIT]))
    else $error("pad polarity does not follow bit 6");

  a_opamp_power: assert property ( // [RQ5]
    (cfg_write && cfg_addr == aqcd_pkg::BYTE_THERMAL)
      |=> thermal_pad_opamp_on == $past(cfg_wdata[aqcd_pkg::OPAMP_BIT]))
    else $error("op amp power does not follow bit 7");

  a_monitor_switch: assert property ( // [RQ6]
    (cfg_write && cfg_addr == aqcd_pkg::BYTE_VOLTAGE)
      |=> current_monitor_switch_on == $past(cfg_wdata[aqcd_pkg::CURMON_BIT]))
    else $error("current monitor switch does not follow bit 4");

  a_scale_select: assert property ( // [RQ12]
    (cfg_write && cfg_addr == aqcd_pkg::BYTE_VOLTAGE)
      |=> voltage_pad_scale == $past(cfg_wdata[aqcd_pkg::SCALE_MSB:aqcd_pkg::SCALE_LSB]))
    else $error("scale does not follow bits 2:0");

  a_gate_current: assert property ( // [RQ7]
    (cfg_write && cfg_addr == aqcd_pkg::BYTE_GATE)
      |=> gate_pad_current == $past(cfg_wdata[aqcd_pkg::DRIVE_MSB:aqcd_pkg::DRIVE_LSB]))
    else $error("gate current does not follow bits 3:2");

  a_gate_polarity: assert property ( // [RQ8]
    (cfg_write && cfg_addr == aqcd_pkg::BYTE_GATE)
      |=> gate_pad_negative == $past(cfg_wdata[aqcd_pkg::GATE_POL_BIT]))
    else $error("gate polarity does not follow bit 6");

  a_gate_off: assert property ( // [RQ9]
    !gate_drive_on_input |-> gate_pad_drive == aqcd_pkg::GATE_OFF)
    else $error("gate driver on without drive-on input");

  a_gate_mode: assert property ( // [RQ9]
    (cfg_write && cfg_addr == aqcd_pkg::BYTE_GATE && gate_drive_on_input)
      ##1 gate_drive_on_input
      |-> gate_pad_drive == ($past(cfg_wdata[aqcd_pkg::HIGH_DRIVE_BIT])
        ? aqcd_pkg::GATE_HIGH_DRIVE : aqcd_pkg::GATE_LOW_DRIVE))
    else $error("gate drive mode does not follow bit 7");

  a_temp_monitor: assert property ( // [RQ10]
    (cfg_write && cfg_addr == aqcd_pkg::BYTE_GATE)
      |=> temp_monitor_enable_control == $past(cfg_wdata[aqcd_pkg::TEMPMON_BIT]))
    else $error("temperature monitor enable does not follow bit 0");

  c_high_drive: cover property (
    gate_drive_on_input && gate_pad_drive == aqcd_pkg::GATE_HIGH_DRIVE);
  c_monitor_route: cover property (
    thermal_pad_route == aqcd_pkg::ROUTE_MONITOR && thermal_pad_opamp_on);
  c_invalid_route: cover property (voltage_pad_route_invalid);
  c_write_then_read: cover property (cfg_write ##1 cfg_read ##1 cfg_rvalid);

endmodule : aqcd_quad_config

// *** verification/aqcd_cfg_model.sv ***
// Behavioural configuring party on the quad configuration port, driven through tasks
`timescale 1ns/1ns
module aqcd_cfg_model (
  input wire logic clk,
  output logic cfg_write,
  output logic cfg_read,
  output logic [1:0] cfg_addr,
  output logic [7:0] cfg_wdata
);
  initial begin
    cfg_write = 1'b0;
    cfg_read = 1'b0;
    cfg_addr = 2'h0;
    cfg_wdata = 8'h00;
  end

  // One request per call, launched and released on falling edges
  task automatic transfer(input logic wr, input logic rd, input logic [1:0] addr,
      input logic [7:0] data, output logic [7:0] stored);
    stored = data;
    if (wr && addr == aqcd_pkg::BYTE_THERMAL) begin
      stored[aqcd_pkg::POLARITY_BIT] = 1'b0;
      // Only two ranges suit the temperature monitor
      stored[2:0] = stored[1] ? aqcd_pkg::SCALE_4V : aqcd_pkg::SCALE_16V;
    end
    @(negedge clk);
    cfg_write = wr;
    cfg_read = rd;
    cfg_addr = addr;
    cfg_wdata = stored;
    @(negedge clk);
    cfg_write = 1'b0;
    cfg_read = 1'b0;
    // Released lines carry junk so stale data cannot pass as a match
    cfg_addr = ~addr;
    cfg_wdata = ~stored;
  endtask : transfer

  // Write, then read the same byte on the very next edge
  task automatic write_read(input logic [1:0] addr, input logic [7:0] data,
      output logic [7:0] stored);
    stored = data;
    if (addr == aqcd_pkg::BYTE_THERMAL) begin
      stored[aqcd_pkg::POLARITY_BIT] = 1'b0;
      stored[2:0] = stored[1] ? aqcd_pkg::SCALE_4V : aqcd_pkg::SCALE_16V;
    end
    @(negedge clk);
    cfg_write = 1'b1;
    cfg_addr = addr;
    cfg_wdata = stored;
    @(negedge clk);
    cfg_write = 1'b0;
    cfg_read = 1'b1;
    @(negedge clk);
    cfg_read = 1'b0;
    cfg_addr = ~addr;
    cfg_wdata = ~stored;
  endtask : write_read
endmodule : aqcd_cfg_model

// *** verification/tb_top.sv ***
// Self-checking bench for the analog quad configuration decoder
`timescale 1ns/1ns
module tb_top;
  logic clk, reset, gate_drive_on_input, cfg_write, cfg_read, cfg_rvalid;
  logic [1:0] cfg_addr;
  logic [7:0] cfg_wdata, cfg_rdata;
  logic [2:0] v_scale, c_scale, t_scale;
  aqcd_pkg::aqcd_route_type v_route, c_route, t_route;
  logic v_inv, v_dir, v_neg, v_op, c_inv, c_dir, c_neg, c_op, t_inv, t_dir, t_neg, t_op;
  logic cur_mon, g_neg, temp_en;
  logic [1:0] g_cur;
  aqcd_pkg::aqcd_drive_type g_drive;
  logic [7:0] shadow [4];
  logic [7:0] read_notes [$];
  int failures, samples_checked, seed_dummy;

  aqcd_quad_config DUT (.clk(clk), .reset(reset), .cfg_write(cfg_write), .cfg_read(cfg_read),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .gate_drive_on_input(gate_drive_on_input), .voltage_pad_scale(v_scale),
    .voltage_pad_route(v_route), .voltage_pad_route_invalid(v_inv),
    .voltage_pad_direct_on(v_dir), .voltage_pad_negative(v_neg), .voltage_pad_opamp_on(v_op),
    .current_monitor_switch_on(cur_mon), .current_pad_scale(c_scale),
    .current_pad_route(c_route), .current_pad_route_invalid(c_inv),
    .current_pad_direct_on(c_dir), .current_pad_negative(c_neg), .current_pad_opamp_on(c_op),
    .thermal_pad_scale(t_scale), .thermal_pad_route(t_route),
    .thermal_pad_route_invalid(t_inv), .thermal_pad_direct_on(t_dir),
    .thermal_pad_negative(t_neg), .thermal_pad_opamp_on(t_op), .gate_pad_current(g_cur),
    .gate_pad_negative(g_neg), .gate_pad_drive(g_drive),
    .temp_monitor_enable_control(temp_en));

  aqcd_cfg_model cfg_model (.clk(clk), .cfg_write(cfg_write), .cfg_read(cfg_read),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata));

  task automatic print_verdict();
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [8:0] pad_exp(input logic [7:0] b);
    aqcd_pkg::aqcd_route_type r;
    case (b[4:3])
      2'h0: r = aqcd_pkg::ROUTE_PRESCALER;
      2'h1: r = aqcd_pkg::ROUTE_DIRECT;
      2'h2: r = aqcd_pkg::ROUTE_MONITOR;
      default: r = aqcd_pkg::ROUTE_NONE;
    endcase
    return {b[4:3] == 2'h3, b[7], b[6], b[5], r, b[2:0]};
  endfunction : pad_exp

  task automatic check_all();
    aqcd_pkg::aqcd_drive_type d;
    d = !gate_drive_on_input ? aqcd_pkg::GATE_OFF :
        shadow[2][7] ? aqcd_pkg::GATE_HIGH_DRIVE : aqcd_pkg::GATE_LOW_DRIVE;
    check("voltage pad", {v_inv, v_op, v_neg, v_dir, v_route, v_scale}, pad_exp(shadow[0]));
    check("current pad", {c_inv, c_op, c_neg, c_dir, c_route, c_scale}, pad_exp(shadow[1]));
    check("thermal pad", {t_inv, t_op, t_neg, t_dir, t_route, t_scale}, pad_exp(shadow[3]));
    check("current monitor", 9'(cur_mon), 9'(shadow[0][4]));
    check("gate current", 9'(g_cur), 9'(shadow[2][3:2]));
    check("gate polarity", 9'(g_neg), 9'(shadow[2][6]));
    check("gate drive", 9'(g_drive), 9'(d));
    check("temp monitor", 9'(temp_en), 9'(shadow[2][0]));
  endtask : check_all

  // A read in the cycle of a write sees the old byte
  task automatic access(input logic wr, input logic rd, input logic [1:0] a,
      input logic [7:0] d);
    logic [7:0] stored;
    if (rd) read_notes.push_back(shadow[a]);
    cfg_model.transfer(wr, rd, a, d, stored);
    if (wr) shadow[a] = stored;
  endtask : access

  task automatic drain();
    int n;
    n = 0;
    while (read_notes.size() != 0 && n < 8) begin
      @(negedge clk);
      n++;
    end
    if (read_notes.size() != 0) begin
      failures++;
      print_verdict();
    end
  endtask : drain

  // Sampled mid-cycle, while the one-cycle answer stands
  always @(negedge clk) begin
    if (cfg_rvalid === 1'b1) begin
      if (read_notes.size() == 0) check("read count", 9'h001, 9'h000);
      else check("read data", 9'(cfg_rdata), 9'(read_notes.pop_front()));
    end
  end

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    print_verdict();
  end

  initial begin
    logic [7:0] d, s;
    int i;
    reset = 1'b1;
    gate_drive_on_input = 1'b0;
    failures = 0;
    samples_checked = 0;
    shadow = '{default: 8'h00};
    seed_dummy = $urandom(59348);
    repeat (6) @(negedge clk);
    reset = 1'b0;
    check_all();
    for (i = 0; i < 4; i++) access(1'b0, 1'b1, 2'(i), 8'h00);
    drain();
    access(1'b1, 1'b0, aqcd_pkg::BYTE_GATE, 8'h01);
    check_all();
    // Every mux code, the invalid one too, reaches each analog pad
    for (i = 0; i < 40; i++) begin
      d = 8'($urandom());
      if (i % 4 != 2) d[4:3] = 2'(i / 4);
      gate_drive_on_input = 1'($urandom());
      access(1'b1, i % 3 == 0, 2'(i), d);
      check_all();
    end
    drain();
    for (i = 0; i < 4; i++) access(1'b0, 1'b1, 2'(i), 8'h00);
    drain();
    // Back-to-back write and read must show the new byte at once
    for (i = 0; i < 4; i++) begin
      d = 8'($urandom());
      if (i == 3) d = {d[7], 1'b0, d[5:3], aqcd_pkg::SCALE_4V};
      read_notes.push_back(d);
      cfg_model.write_read(2'(i), d, s);
      shadow[i] = s;
      check_all();
    end
    drain();
    access(1'b1, 1'b0, aqcd_pkg::BYTE_VOLTAGE, 8'hff);
    reset = 1'b1;
    @(negedge clk);
    reset = 1'b0;
    shadow = '{default: 8'h00};
    check_all();
    for (i = 0; i < 4; i++) access(1'b0, 1'b1, 2'(i), 8'h00);
    drain();
    print_verdict();
  end
endmodule : tb_top
